/* rtl/agc_consts.svh */
// offsets, field positions, reset values and limits of the brightness control block
`ifndef AGC_CONSTS_SVH
`define AGC_CONSTS_SVH
// register byte offsets
`define AGC_OFS_CTRL 8'h00
`define AGC_OFS_TARGET 8'h04
`define AGC_OFS_GMAN 8'h08
`define AGC_OFS_GFLR 8'h0C
`define AGC_OFS_GCEIL 8'h10
`define AGC_OFS_EMAN 8'h14
`define AGC_OFS_EFLR 8'h18
`define AGC_OFS_ECEIL 8'h1C
`define AGC_OFS_W0XY 8'h20
`define AGC_OFS_W0WH 8'h24
`define AGC_OFS_W1XY 8'h28
`define AGC_OFS_W1WH 8'h2C
`define AGC_OFS_IXY 8'h30
`define AGC_OFS_IWH 8'h34
`define AGC_OFS_GOUT 8'h38
`define AGC_OFS_EOUT 8'h3C
`define AGC_OFS_STAT 8'h40
// control field positions
`define AGC_CTRL_GMODE 0
`define AGC_CTRL_EMODE 2
`define AGC_CTRL_WSEL 4
`define AGC_CTRL_PIX12 5
`define AGC_CTRL_TRIGW 6
`define AGC_CTRL_BIN 7
`define AGC_CTRL_BSH 8
`define AGC_CTRL_PROF 10
`define AGC_CTRL_NOLIM 11
// reset values
`define AGC_RST_CTRL 12'h000
`define AGC_RST_TARGET 16'h8080
`define AGC_RST_GMAN 12'h000
`define AGC_RST_GFLR 12'h000
`define AGC_RST_GCEIL 12'h0FF
`define AGC_RST_EMAN 20'h0_2710
`define AGC_RST_EFLR 20'h0_0064
`define AGC_RST_ECEIL 20'h0_C350
`define AGC_RST_WW 12'h800
`define AGC_RST_WH 12'h600
// gray full scale, gain/exposure bounds, gray dead band and step sizes
`define AGC_FULL8 12'h0FF
`define AGC_FULL12 12'hFFF
`define AGC_GMIN8 12'h000
`define AGC_GMAX8 12'h3FF
`define AGC_GMIN12 12'h040
`define AGC_GMAX12 12'h2FF
`define AGC_GMAXBIN 12'h1FF
`define AGC_GABSMAX 12'hFFF
`define AGC_EMIN 20'h0_000A
`define AGC_EMAX 20'hF_FFFF
`define AGC_TOL 12'h002
`define AGC_GSTEP 12'h004
`define AGC_ESTEP 20'h0_0040
`endif

/* rtl/agc_pkg.sv */
// types shared by the brightness control block
package agc_pkg;
	// per-function operating mode, 2'b11 is illegal
	typedef enum logic [1:0] {AGC_OFF = 2'b00, AGC_ONCE = 2'b01, AGC_CONT = 2'b10} agc_mode_t;
	// controller sequence
	typedef enum logic [1:0] {AGC_WAIT = 2'b00, AGC_MUL = 2'b01, AGC_STEP = 2'b10} agc_state_t;
endpackage

/* rtl/agc_stat_if.sv */
// carrier between the controller and the window statistics unit
`timescale 1ns/1ps
`default_nettype none
interface agc_stat_if;
	logic pv; // synced pixel valid
	logic fv; // synced frame valid
	logic lv; // synced line valid
	logic [11:0] pix; // synced gray value
	logic bin; // binning on
	logic [1:0] bsh; // binning shift
	logic [11:0] wx, wy, ww, wh; // statistics window
	logic [11:0] ix, iy, iw, ih; // image output window
	logic [39:0] sum; // sum of overlapped pixels
	logic [23:0] cnt; // number of overlapped pixels
	logic done; // frame statistics ready pulse
	modport ctl (output pv, fv, lv, pix, bin, bsh, wx, wy, ww, wh, ix, iy, iw, ih,
		input sum, cnt, done);
	modport stat (input pv, fv, lv, pix, bin, bsh, wx, wy, ww, wh, ix, iy, iw, ih,
		output sum, cnt, done);
endinterface
`default_nettype wire

/* rtl/agc_stats.sv */
// window statistics: sums gray values in the window and image overlap
`timescale 1ns/1ps
`default_nettype none
module agc_stats
(
	input wire logic clk,
	input wire logic rst_n,
	agc_stat_if.stat sif
);
	//--------------------------------------------------
	// coordinates
	//--------------------------------------------------
	logic [11:0] col, row; // physical position
	logic fv_q, lv_q; // previous levels for edges
	logic [39:0] acc; // running sum
	logic [23:0] n; // running count
	// binned mode addresses virtual columns and lines
	wire [11:0] vx = sif.bin ? (col >> sif.bsh) : col;
	wire [11:0] vy = sif.bin ? (row >> sif.bsh) : row;
	wire in_w = vx >= sif.wx && 13'(vx) < 13'(sif.wx) + 13'(sif.ww)
		&& vy >= sif.wy && 13'(vy) < 13'(sif.wy) + 13'(sif.wh);
	wire in_i = vx >= sif.ix && 13'(vx) < 13'(sif.ix) + 13'(sif.iw)
		&& vy >= sif.iy && 13'(vy) < 13'(sif.iy) + 13'(sif.ih);
	wire take = sif.pv && sif.lv && in_w && in_i; // only the intersection counts
	wire sof = sif.fv && !fv_q;
	wire eof = !sif.fv && fv_q;
	//--------------------------------------------------
	// counters and accumulator
	//--------------------------------------------------
	// position advances per pixel, lines on line-valid fall
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			col <= 12'h000; row <= 12'h000; fv_q <= 1'b0; lv_q <= 1'b0;
			acc <= 40'h00_0000_0000; n <= 24'h00_0000;
			sif.sum <= 40'h00_0000_0000; sif.cnt <= 24'h00_0000; sif.done <= 1'b0;
		end
		else
		begin
			fv_q <= sif.fv; lv_q <= sif.lv;
			sif.done <= eof;
			if (sof)
			begin
				// fresh frame, clear statistics
				row <= 12'h000; col <= 12'h000; acc <= 40'h00_0000_0000; n <= 24'h00_0000;
			end
			else
			begin
				if (sif.pv && sif.lv) col <= col + 12'h001;
				if (!sif.lv && lv_q)
				begin
					col <= 12'h000; row <= row + 12'h001;
				end
				if (take)
				begin
					acc <= acc + 40'(sif.pix); n <= n + 24'h00_0001;
				end
			end
			if (eof)
			begin
				sif.sum <= acc; sif.cnt <= n;
			end
		end
	end
	chk_stat_outside: assert property (@(posedge clk) disable iff (!rst_n)
		(!take && !sof) |=> n == $past(n)) else $error("count moved outside overlap");
endmodule
`default_nettype wire

/* rtl/agc_top.sv */
// automatic gain and exposure control with APB registers
//--------------------------------------------------
// Behaviour
// - binned mode uses virtual window coordinates
// - auto gain steps gain toward target
// - gain offers once and continuous modes
// - no overlap: gain follows manual value
// - auto gain kept between floor and ceiling
// - gain bounds from format, binning, unlock
// - target gray 0-255 or 0-4095
// - fraction scales to format gray range
// - trigger-width mode disables auto exposure
// - auto exposure steps exposure toward target
// - either window, once or continuous exposure
// - no overlap: exposure follows manual value
// - exposure limits bounded by model range
// - average only over window-image overlap
//--------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "agc_consts.svh"
module agc_top
#(
	parameter logic [11:0] TOL = `AGC_TOL, // gray dead band
	parameter logic [11:0] GSTEP = `AGC_GSTEP, // gain step per frame
	parameter logic [19:0] ESTEP = `AGC_ESTEP, // exposure step per frame
	parameter logic [19:0] EMIN = `AGC_EMIN, // model minimum exposure
	parameter logic [19:0] EMAX = `AGC_EMAX // model maximum exposure
)
(
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic FRAME_VALID_I,
	input wire logic LINE_VALID_I,
	input wire logic PIX_VALID_I,
	input wire logic [11:0] PIX_DATA_I,
	output logic [11:0] GAIN_O,
	output logic [19:0] EXPOSURE_O
);
	//--------------------------------------------------
	// reset release and pin synchronisers
	//--------------------------------------------------
	logic clk;
	logic rst_m, rst_n; // reset release pair
	logic [14:0] pin_m, pin_s; // pixel pins, two stages
	assign clk = MCLK_I;
	// reset asserts at once, releases after two edges
	always_ff @(posedge clk or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rst_m <= 1'b0; rst_n <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1; rst_n <= rst_m;
		end
	end
	// pixel pins come from the sensor domain
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_m <= 15'h0000; pin_s <= 15'h0000;
		end
		else
		begin
			pin_m <= {FRAME_VALID_I, LINE_VALID_I, PIX_VALID_I, PIX_DATA_I};
			pin_s <= pin_m;
		end
	end
	//--------------------------------------------------
	// registers
	//--------------------------------------------------
	logic [11:0] ctrl; // modes and options
	logic [15:0] target; // target fraction, 0.16 fixed point
	logic [11:0] gain_man, gain_floor, gain_ceiling; // gain settings
	logic [19:0] exp_man, exposure_floor, exposure_ceiling; // exposure settings
	logic [23:0] w0xy, w0wh, w1xy, w1wh, ixy, iwh; // windows, y in [23:12]
	logic [11:0] gain_auto; // automatically adjusted gain
	logic [19:0] exp_auto; // automatically adjusted exposure
	logic hit, stuck; // last evaluation result
	logic pready; // access-phase wait flag
	agc_pkg::agc_state_t st; // controller state
	logic [39:0] sum_q, lo_thr, hi_thr; // frame sum and thresholds
	logic [23:0] cnt_q; // frame pixel count
	// bus decode
	wire acc = PSEL_I && PENABLE_I;
	wire wr = acc && pready && PWRITE_I;
	wire wr_ctrl = wr && PADDR_I == `AGC_OFS_CTRL;
	wire [1:0] gm_bits = ctrl[`AGC_CTRL_GMODE +: 2];
	wire [1:0] em_bits = ctrl[`AGC_CTRL_EMODE +: 2];
	wire gm_once = gm_bits == agc_pkg::AGC_ONCE;
	wire em_once = em_bits == agc_pkg::AGC_ONCE;
	wire gain_act = gm_once || gm_bits == agc_pkg::AGC_CONT;
	wire trigw = ctrl[`AGC_CTRL_TRIGW];
	wire exp_act = (em_once || em_bits == agc_pkg::AGC_CONT) && !trigw;
	wire pix12 = ctrl[`AGC_CTRL_PIX12];
	// read selection, unmapped offsets raise an error
	wire rd_ok = PADDR_I <= `AGC_OFS_STAT && PADDR_I[1:0] == 2'b00;
	wire [31:0] rd_val =
		PADDR_I == `AGC_OFS_CTRL ? {20'h0_0000, ctrl} :
		PADDR_I == `AGC_OFS_TARGET ? {16'h0000, target} :
		PADDR_I == `AGC_OFS_GMAN ? {20'h0_0000, gain_man} :
		PADDR_I == `AGC_OFS_GFLR ? {20'h0_0000, gain_floor} :
		PADDR_I == `AGC_OFS_GCEIL ? {20'h0_0000, gain_ceiling} :
		PADDR_I == `AGC_OFS_EMAN ? {12'h000, exp_man} :
		PADDR_I == `AGC_OFS_EFLR ? {12'h000, exposure_floor} :
		PADDR_I == `AGC_OFS_ECEIL ? {12'h000, exposure_ceiling} :
		PADDR_I == `AGC_OFS_W0XY ? {4'h0, w0xy[23:12], 4'h0, w0xy[11:0]} :
		PADDR_I == `AGC_OFS_W0WH ? {4'h0, w0wh[23:12], 4'h0, w0wh[11:0]} :
		PADDR_I == `AGC_OFS_W1XY ? {4'h0, w1xy[23:12], 4'h0, w1xy[11:0]} :
		PADDR_I == `AGC_OFS_W1WH ? {4'h0, w1wh[23:12], 4'h0, w1wh[11:0]} :
		PADDR_I == `AGC_OFS_IXY ? {4'h0, ixy[23:12], 4'h0, ixy[11:0]} :
		PADDR_I == `AGC_OFS_IWH ? {4'h0, iwh[23:12], 4'h0, iwh[11:0]} :
		PADDR_I == `AGC_OFS_GOUT ? {20'h0_0000, GAIN_O} :
		PADDR_I == `AGC_OFS_EOUT ? {12'h000, EXPOSURE_O} :
		PADDR_I == `AGC_OFS_STAT ? {29'h0000_0000, stuck, hit, cnt_q != 24'h00_0000} :
		32'h0000_0000;
	// one wait state, then answer with registered data
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0; PRDATA_O <= 32'h0000_0000; PSLVERR_O <= 1'b0;
		end
		else
		begin
			pready <= acc && !pready;
			if (acc && !pready)
			begin
				PRDATA_O <= rd_val; PSLVERR_O <= !rd_ok;
			end
		end
	end
	assign PREADY_O = pready;
	//--------------------------------------------------
	// limits and target
	//--------------------------------------------------
	// allowed gain range depends on format, binning, unlock
	wire [11:0] g_min = ctrl[`AGC_CTRL_NOLIM] ? 12'h000 : pix12 ? `AGC_GMIN12 : `AGC_GMIN8;
	wire [11:0] g_max_f = pix12 ? `AGC_GMAX12 : `AGC_GMAX8;
	wire [11:0] g_max = ctrl[`AGC_CTRL_NOLIM] ? `AGC_GABSMAX :
		ctrl[`AGC_CTRL_BIN] ? `AGC_GMAXBIN : g_max_f;
	wire [11:0] g_flr = gain_floor < g_min ? g_min : gain_floor > g_max ? g_max : gain_floor;
	wire [11:0] g_ceil = gain_ceiling > g_max ? g_max :
		gain_ceiling < g_flr ? g_flr : gain_ceiling;
	// exposure limits held inside the model range
	wire [19:0] e_flr = exposure_floor < EMIN ? EMIN :
		exposure_floor > EMAX ? EMAX : exposure_floor;
	wire [19:0] e_ceil = exposure_ceiling > EMAX ? EMAX :
		exposure_ceiling < e_flr ? e_flr : exposure_ceiling;
	// fraction times full scale, rounded to nearest gray
	wire [11:0] full = pix12 ? `AGC_FULL12 : `AGC_FULL8;
	wire [27:0] gprod = 28'(target) * 28'(full) + 28'h000_8000;
	wire [11:0] gray = gprod[27:16];
	wire [12:0] gray_hi = 13'(gray) + 13'(TOL);
	wire [11:0] gray_lo = gray > TOL ? gray - TOL : 12'h000;
	//--------------------------------------------------
	// step decision
	//--------------------------------------------------
	wire no_ov = cnt_q == 24'h00_0000; // window misses image
	wire dark = sum_q < lo_thr;
	wire bright = sum_q > hi_thr;
	wire [11:0] g_cl = gain_auto < g_flr ? g_flr : gain_auto > g_ceil ? g_ceil : gain_auto;
	wire [19:0] e_cl = exp_auto < e_flr ? e_flr : exp_auto > e_ceil ? e_ceil : exp_auto;
	wire [12:0] g_sum = 13'(g_cl) + 13'(GSTEP);
	wire [11:0] g_up = g_sum > 13'(g_ceil) ? g_ceil : g_sum[11:0];
	wire [11:0] g_dn = 13'(g_cl) < 13'(g_flr) + 13'(GSTEP) ? g_flr : g_cl - GSTEP;
	wire [20:0] e_sum = 21'(e_cl) + 21'(ESTEP);
	wire [19:0] e_up = e_sum > 21'(e_ceil) ? e_ceil : e_sum[19:0];
	wire [19:0] e_dn = 21'(e_cl) < 21'(e_flr) + 21'(ESTEP) ? e_flr : e_cl - ESTEP;
	wire up_g = gain_act && g_cl < g_ceil;
	wire dn_g = gain_act && g_cl > g_flr;
	wire up_e = exp_act && e_cl < e_ceil;
	wire dn_e = exp_act && e_cl > e_flr;
	// profile: when clear, exposure rises first and gain falls first, so gain stays low
	wire min_gain = !ctrl[`AGC_CTRL_PROF];
	wire mv_eu = dark && up_e && (min_gain || !up_g);
	wire mv_gu = dark && up_g && !mv_eu;
	wire mv_gd = bright && dn_g && (min_gain || !dn_e);
	wire mv_ed = bright && dn_e && !mv_gd;
	wire next_hit = !no_ov && !dark && !bright;
	wire next_stuck = !no_ov && (dark || bright) && !(mv_eu || mv_gu || mv_gd || mv_ed);
	wire fin = no_ov || next_hit || next_stuck; // once run ends
	//--------------------------------------------------
	// statistics unit
	//--------------------------------------------------
	agc_stat_if sif ();
	wire wsel = ctrl[`AGC_CTRL_WSEL]; // either window feeds brightness
	assign sif.fv = pin_s[14];
	assign sif.lv = pin_s[13];
	assign sif.pv = pin_s[12];
	assign sif.pix = pin_s[11:0];
	assign sif.bin = ctrl[`AGC_CTRL_BIN];
	assign sif.bsh = ctrl[`AGC_CTRL_BSH +: 2];
	assign {sif.wy, sif.wx} = wsel ? w1xy : w0xy;
	assign {sif.wh, sif.ww} = wsel ? w1wh : w0wh;
	assign {sif.iy, sif.ix} = ixy;
	assign {sif.ih, sif.iw} = iwh;
	agc_stats u_stats (.clk(clk), .rst_n(rst_n), .sif(sif));
	//--------------------------------------------------
	// register writes and mode bookkeeping
	//--------------------------------------------------
	// a bus write to the control word wins over the once clear, being the later assignment;
	// writes to other registers must not swallow the clear, or a once run never ends
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= `AGC_RST_CTRL; target <= `AGC_RST_TARGET;
			gain_man <= `AGC_RST_GMAN; gain_floor <= `AGC_RST_GFLR;
			gain_ceiling <= `AGC_RST_GCEIL; exp_man <= `AGC_RST_EMAN;
			exposure_floor <= `AGC_RST_EFLR; exposure_ceiling <= `AGC_RST_ECEIL;
			w0xy <= 24'h00_0000; w1xy <= 24'h00_0000; ixy <= 24'h00_0000;
			w0wh <= {`AGC_RST_WH, `AGC_RST_WW}; w1wh <= {`AGC_RST_WH, `AGC_RST_WW};
			iwh <= {`AGC_RST_WH, `AGC_RST_WW};
		end
		else
		begin
			// single-shot functions fall back to off
			if (st == agc_pkg::AGC_STEP && fin)
			begin
				if (gm_once) ctrl[`AGC_CTRL_GMODE +: 2] <= agc_pkg::AGC_OFF;
				if (em_once) ctrl[`AGC_CTRL_EMODE +: 2] <= agc_pkg::AGC_OFF;
			end
			if (wr)
			begin
			unique case (PADDR_I)
				`AGC_OFS_CTRL: ctrl <= PWDATA_I[11:0];
				`AGC_OFS_TARGET: target <= PWDATA_I[15:0];
				`AGC_OFS_GMAN: gain_man <= PWDATA_I[11:0];
				`AGC_OFS_GFLR: gain_floor <= PWDATA_I[11:0];
				`AGC_OFS_GCEIL: gain_ceiling <= PWDATA_I[11:0];
				`AGC_OFS_EMAN: exp_man <= PWDATA_I[19:0];
				`AGC_OFS_EFLR: exposure_floor <= PWDATA_I[19:0];
				`AGC_OFS_ECEIL: exposure_ceiling <= PWDATA_I[19:0];
				`AGC_OFS_W0XY: w0xy <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				`AGC_OFS_W0WH: w0wh <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				`AGC_OFS_W1XY: w1xy <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				`AGC_OFS_W1WH: w1wh <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				`AGC_OFS_IXY: ixy <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				`AGC_OFS_IWH: iwh <= {PWDATA_I[27:16], PWDATA_I[11:0]};
				default: ; // read-only and unmapped writes ignored
			endcase
			end
		end
	end
	//--------------------------------------------------
	// closed loop
	//--------------------------------------------------
	// sequence: frame done, thresholds, one step per frame
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= agc_pkg::AGC_WAIT; sum_q <= 40'h00_0000_0000; cnt_q <= 24'h00_0000;
			lo_thr <= 40'h00_0000_0000; hi_thr <= 40'h00_0000_0000;
			gain_auto <= `AGC_RST_GMAN; exp_auto <= `AGC_RST_EMAN;
			hit <= 1'b0; stuck <= 1'b0;
		end
		else
		begin
			unique case (st)
				agc_pkg::AGC_WAIT:
				begin
					if (sif.done)
					begin
						sum_q <= sif.sum; cnt_q <= sif.cnt; st <= agc_pkg::AGC_MUL;
					end
				end
				agc_pkg::AGC_MUL:
				begin
					// average compared as sum against gray times count
					lo_thr <= 40'(gray_lo) * 40'(cnt_q);
					hi_thr <= 40'(gray_hi) * 40'(cnt_q);
					st <= agc_pkg::AGC_STEP;
				end
				agc_pkg::AGC_STEP:
				begin
					hit <= next_hit; stuck <= next_stuck; st <= agc_pkg::AGC_WAIT;
					if (no_ov)
					begin
						gain_auto <= gain_man; exp_auto <= exp_man;
					end
					else
					begin
						gain_auto <= mv_gu ? g_up : mv_gd ? g_dn : g_cl;
						exp_auto <= mv_eu ? e_up : mv_ed ? e_dn : e_cl;
					end
				end
				default: st <= agc_pkg::AGC_WAIT;
			endcase
			// inactive functions track manual, so a run starts there
			if (!gain_act) gain_auto <= gain_man;
			if (!exp_act) exp_auto <= exp_man;
		end
	end
	// outputs select auto or manual value
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			GAIN_O <= `AGC_RST_GMAN; EXPOSURE_O <= `AGC_RST_EMAN;
		end
		else
		begin
			GAIN_O <= gain_act ? gain_auto : gain_man;
			EXPOSURE_O <= exp_act ? exp_auto : exp_man;
		end
	end
	//--------------------------------------------------
	// checks
	//--------------------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_gain_limits: assert property ((st == agc_pkg::AGC_STEP && gain_act && !no_ov)
		|=> gain_auto >= $past(g_flr) && gain_auto <= $past(g_ceil)) else $error("gain out");
	chk_exp_limits: assert property ((st == agc_pkg::AGC_STEP && exp_act && !no_ov)
		|=> exp_auto >= $past(e_flr) && exp_auto <= $past(e_ceil)) else $error("exp out");
	chk_trig_manual: assert property (trigw
		|=> EXPOSURE_O == $past(exp_man)) else $error("auto exposure in trigger width");
	chk_gain_noov: assert property ((st == agc_pkg::AGC_STEP && no_ov && gain_act)
		|=> gain_auto == $past(gain_man)) else $error("gain not manual");
	chk_exp_noov: assert property ((st == agc_pkg::AGC_STEP && no_ov && exp_act)
		|=> exp_auto == $past(exp_man)) else $error("exposure not manual");
	chk_once_off: assert property ((st == agc_pkg::AGC_STEP && fin && gm_once && !wr_ctrl)
		|=> gm_bits == agc_pkg::AGC_OFF) else $error("once gain not ended");
	chk_cont_stays: assert property ((gm_bits == agc_pkg::AGC_CONT && !wr_ctrl)
		|=> gm_bits == agc_pkg::AGC_CONT) else $error("continuous gain ended");
	chk_gray_range: assert property (gray <= full) else $error("target gray past full");
	chk_gain_bounds: assert property (g_flr >= g_min && g_ceil <= g_max)
		else $error("gain limits outside allowed");
	chk_step_gain: assert property ((st == agc_pkg::AGC_STEP && mv_gu)
		|=> gain_auto > $past(gain_auto) || $past(gain_auto) < $past(g_flr))
		else $error("gain step lost");
	chk_step_exp: assert property ((st == agc_pkg::AGC_STEP && mv_ed)
		|=> exp_auto < $past(exp_auto) || $past(exp_auto) > $past(e_ceil))
		else $error("exposure step lost");
endmodule
`default_nettype wire

/* test/agc_sensor_model.sv */
// sensor frame source model for the brightness control bench
`timescale 1ns/1ps
`default_nettype none
module agc_sensor_model
#(
	parameter int COLS = 8, // pixels per line
	parameter int ROWS = 4 // lines per frame
)
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [11:0] gray_i,
	output logic fv_o,
	output logic lv_o,
	output logic pv_o,
	output logic [11:0] pix_o,
	output logic busy_o
);
	//----------------------------------------
	// frame generator
	//----------------------------------------
	// data lines change outside lines so a stale value never passes as a pixel
	initial
	begin
		fv_o = 1'b0;
		lv_o = 1'b0;
		pv_o = 1'b0;
		pix_o = 12'h000;
		busy_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (go_i)
			begin
				busy_o <= 1'b1;
				fv_o <= 1'b1;
				repeat (2) @(posedge clk_i);
				for (int r = 0; r < ROWS; r++)
				begin
					lv_o <= 1'b1;
					pv_o <= 1'b1;
					pix_o <= gray_i;
					repeat (COLS) @(posedge clk_i);
					lv_o <= 1'b0;
					pv_o <= 1'b0;
					pix_o <= ~gray_i;
					repeat (2) @(posedge clk_i);
				end
				fv_o <= 1'b0;
				pix_o <= gray_i ^ 12'h05A5;
				@(posedge clk_i);
				busy_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* test/agc_top_bench.sv */
// self-checking bench for the brightness control block
`timescale 1ns/1ps
`default_nettype none
`include "agc_consts.svh"
module agc_top_bench;
	//----------------------------------------
	// stimulus and observed signals
	//----------------------------------------
	logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [11:0] gray = 12'h000;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, fv, lv, pv, busy;
	wire logic [11:0] pix, gain;
	wire logic [19:0] expo;
	int num_errors = 0, n_tests = 0, cycles = 0;
	always #50 mclk = ~mclk;
	agc_top i_agc_top (.MCLK_I(mclk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_VALID_I(fv), .LINE_VALID_I(lv),
		.PIX_VALID_I(pv), .PIX_DATA_I(pix), .GAIN_O(gain), .EXPOSURE_O(expo));
	agc_sensor_model i_agc_sensor_model (.clk_i(mclk), .go_i(go), .gray_i(gray), .fv_o(fv),
		.lv_o(lv), .pv_o(pv), .pix_o(pix), .busy_o(busy));
	//----------------------------------------
	// shared tasks
	//----------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no local limit: the cycle ceiling below ends a hung wait
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r & m, exp);
	endtask
	// one frame of flat gray, then the settle time of the step pipeline
	task automatic frame(input logic [11:0] g);
		gray <= g;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		do
		begin
			@(posedge mclk);
		end
		while (busy);
		repeat (10) @(posedge mclk);
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rdchk(`AGC_OFS_TARGET, 32'h0000_FFFF, 32'(`AGC_RST_TARGET));
		rdchk(`AGC_OFS_ECEIL, 32'h000F_FFFF, 32'(`AGC_RST_ECEIL));
		check(32'(expo), 32'(`AGC_RST_EMAN));
		apb(1'b0, 8'h44, 32'h0000_0000, r, e);
		check(32'(e), 32'h0000_0001);
	endtask
	task automatic t_gain_cont();
		wr(`AGC_OFS_GMAN, 32'h0000_0010);
		// limits only ever act on the all-channel gain, the one gain there is
		wr(`AGC_OFS_GCEIL, 32'h0000_0018);
		wr(`AGC_OFS_CTRL, 32'h0000_0002);
		frame(12'h010);
		check(32'(gain), 32'h0000_0014);
		frame(12'h010);
		frame(12'h010);
		check(32'(gain), 32'h0000_0018);
		rdchk(`AGC_OFS_CTRL, 32'h0000_0003, 32'h0000_0002);
		rdchk(`AGC_OFS_STAT, 32'h0000_0001, 32'h0000_0001);
		wr(`AGC_OFS_CTRL, 32'h0000_0001);
		frame(12'h080);
		rdchk(`AGC_OFS_CTRL, 32'h0000_0003, 32'h0000_0000);
	endtask
	// statistics window moved fully right of the image window
	task automatic t_no_overlap();
		wr(`AGC_OFS_W0XY, 32'h0000_0900);
		wr(`AGC_OFS_GMAN, 32'h0000_0030);
		wr(`AGC_OFS_CTRL, 32'h0000_0002);
		frame(12'h010);
		check(32'(gain), 32'h0000_0030);
		rdchk(`AGC_OFS_STAT, 32'h0000_0001, 32'h0000_0000);
		// binned by two: columns 0-7 become virtual 0-3, so x 4 misses them
		wr(`AGC_OFS_W0XY, 32'h0000_0004);
		wr(`AGC_OFS_CTRL, 32'h0000_0182);
		frame(12'h010);
		rdchk(`AGC_OFS_STAT, 32'h0000_0001, 32'h0000_0000);
		check(32'(gain), 32'h0000_0030);
		wr(`AGC_OFS_CTRL, 32'h0000_0002);
		frame(12'h010);
		rdchk(`AGC_OFS_STAT, 32'h0000_0001, 32'h0000_0001);
		check(32'(gain), 32'h0000_0018);
		wr(`AGC_OFS_W0XY, 32'h0000_0000);
	endtask
	task automatic t_exposure();
		wr(`AGC_OFS_CTRL, 32'h0000_0008);
		frame(12'h010);
		check(32'(expo), 32'h0_2750);
		wr(`AGC_OFS_CTRL, 32'h0000_0048);
		frame(12'h010);
		check(32'(expo), 32'h0_2710);
		// window 1 off the image first, then back on it
		wr(`AGC_OFS_W1XY, 32'h0000_0900);
		wr(`AGC_OFS_CTRL, 32'h0000_0018);
		frame(12'h010);
		check(32'(expo), 32'h0_2710);
		wr(`AGC_OFS_W1XY, 32'h0000_0000);
		frame(12'h010);
		check(32'(expo), 32'h0_2750);
	endtask
	// 0x0F0 is bright on the 8 bit scale but dark on the 12 bit one
	task automatic t_format();
		wr(`AGC_OFS_CTRL, 32'h0000_0000);
		wr(`AGC_OFS_GCEIL, 32'h0000_00FF);
		wr(`AGC_OFS_GMAN, 32'h0000_0080);
		wr(`AGC_OFS_CTRL, 32'h0000_0022);
		frame(12'h0F0);
		check(32'(gain), 32'h0000_0084);
		wr(`AGC_OFS_CTRL, 32'h0000_0002);
		frame(12'h0F0);
		check(32'(gain), 32'h0000_0080);
		wr(`AGC_OFS_CTRL, 32'h0000_0000);
		wr(`AGC_OFS_GMAN, 32'h0000_0044);
		wr(`AGC_OFS_CTRL, 32'h0000_0022);
		frame(12'hFFF);
		frame(12'hFFF);
		check(32'(gain), 32'h0000_0040);
		// unlocked limits let gain sink below the 12 bit floor
		wr(`AGC_OFS_CTRL, 32'h0000_0822);
		frame(12'hFFF);
		check(32'(gain), 32'h0000_003C);
		// profile set with both running: on a dark frame gain rises before exposure
		wr(`AGC_OFS_CTRL, 32'h0000_040A);
		frame(12'h010);
		check(32'(gain), 32'h0000_0040);
		check(32'(expo), 32'h0_2710);
		wr(`AGC_OFS_CTRL, 32'h0000_000A);
		frame(12'h010);
		check(32'(expo), 32'h0_2750);
		check(32'(gain), 32'h0000_0040);
	endtask
	//----------------------------------------
	// main sequence and hang guard
	//----------------------------------------
	initial
	begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_gain_cont();
		t_no_overlap();
		t_exposure();
		t_format();
		close_out();
	end
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			close_out();
		end
	end
endmodule
`default_nettype wire
